//--- design/wde_top.sv
// watchdog event selection, control, timeout counter and apb register file
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module wde_top #(
  parameter int unsigned CYC_PER_SEC = wde_pkg::CYCLES_PER_SECOND,
  parameter int unsigned SEC_PER_MIN = wde_pkg::SECONDS_PER_MINUTE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic game_port_access,
  input wire logic kbd_irq,
  input wire logic mouse_irq,
  input wire logic kbc_reset_request_line,
  output logic watchdog_timeout,
  output logic irq
);
  logic [7:0] evsel_ff;
  logic ctrl_status_ff;
  logic ctrl_kbc_en_ff;
  logic [7:0] timeout_ff;
  logic units_sec_ff;
  logic [1:0] ist_ff;
  logic [1:0] imask_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [31:0] pre_ff;
  logic [7:0] min_ff;
  wde_pkg::wde_state_t state_ff;
  wde_pkg::wde_state_t nxt_state;

  logic setup;
  logic wr_en;
  logic wr_evsel;
  logic wr_ctrl;
  logic wr_timeout;
  logic wr_units;
  logic wr_istat;
  logic wr_imask;
  logic kbc_level;
  logic kbc_rise;
  logic act_restart;
  logic reload;
  logic [7:0] reload_val;
  logic force_evt;
  logic sec_tick;
  logic unit_tick;
  logic expire;
  logic timeout_evt;
  logic [1:0] ist_set;

  // apb: zero wait states, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign wr_evsel = wr_en && (paddr == wde_pkg::ADDR_EVSEL);
  assign wr_ctrl = wr_en && (paddr == wde_pkg::ADDR_CTRL);
  assign wr_timeout = wr_en && (paddr == wde_pkg::ADDR_TIMEOUT);
  assign wr_units = wr_en && (paddr == wde_pkg::ADDR_UNITS);
  assign wr_istat = wr_en && (paddr == wde_pkg::ADDR_ISTAT);
  assign wr_imask = wr_en && (paddr == wde_pkg::ADDR_IMASK);
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= wde_pkg::RD_ZERO;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= wde_pkg::RD_ZERO;
      pslverr_ff <= 1'b0;
      case (paddr)
        wde_pkg::ADDR_EVSEL: begin
          prdata_ff[7:0] <= evsel_ff;
        end
        wde_pkg::ADDR_CTRL: begin
          // force bit and reserved bits always read back as zero
          prdata_ff[wde_pkg::CTRL_STATUS] <= ctrl_status_ff;
          prdata_ff[wde_pkg::CTRL_KBC_EN] <= ctrl_kbc_en_ff;
        end
        wde_pkg::ADDR_TIMEOUT: begin
          prdata_ff[7:0] <= timeout_ff;
        end
        wde_pkg::ADDR_UNITS: begin
          prdata_ff[wde_pkg::UNITS_SEC] <= units_sec_ff;
        end
        wde_pkg::ADDR_ISTAT: begin
          prdata_ff[1:0] <= ist_ff;
        end
        wde_pkg::ADDR_IMASK: begin
          prdata_ff[1:0] <= imask_ff;
        end
        default: begin
          pslverr_ff <= 1'b1;
        end
      endcase
    end
  end

  // event select; only the three documented enables are held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evsel_ff <= wde_pkg::RST_EVSEL;
    end else if (wr_evsel) begin
      evsel_ff <= {5'h00, pwdata[2:0]};
    end
  end

  // timeout value and units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_ff <= wde_pkg::RST_TIMEOUT;
      units_sec_ff <= wde_pkg::RST_UNITS[wde_pkg::UNITS_SEC];
    end else begin
      if (wr_timeout) begin
        timeout_ff <= pwdata[7:0];
      end
      if (wr_units) begin
        units_sec_ff <= pwdata[wde_pkg::UNITS_SEC];
      end
    end
  end

  // control register; bits 7:4 and 1 are not stored, so stray ones do no harm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_kbc_en_ff <= wde_pkg::RST_CTRL[wde_pkg::CTRL_KBC_EN];
      ctrl_status_ff <= wde_pkg::RST_CTRL[wde_pkg::CTRL_STATUS];
    end else begin
      if (wr_ctrl) begin
        ctrl_kbc_en_ff <= pwdata[wde_pkg::CTRL_KBC_EN];
      end
      // a timeout in the same cycle as a software clear wins
      if (timeout_evt) begin
        ctrl_status_ff <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_status_ff <= pwdata[wde_pkg::CTRL_STATUS];
      end
    end
  end

  wde_sync u_kbc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(kbc_reset_request_line),
    .level(kbc_level),
    .rise(kbc_rise)
  );

  // restart and timeout sources
  assign act_restart = (game_port_access && evsel_ff[wde_pkg::EVSEL_JOY])
    || (kbd_irq && evsel_ff[wde_pkg::EVSEL_KBD])
    || (mouse_irq && evsel_ff[wde_pkg::EVSEL_MOUSE]);
  assign reload = act_restart || wr_timeout;
  // a count write reloads with the new value, not the one it replaces
  assign reload_val = wr_timeout ? pwdata[7:0] : timeout_ff;
  // force bit is independent of the line enable
  assign force_evt = (wr_ctrl && pwdata[wde_pkg::CTRL_FORCE])
    || (kbc_rise && ctrl_kbc_en_ff);

  // prescaler: seconds, then minutes; only runs while counting
  assign sec_tick = (state_ff == wde_pkg::WDE_COUNT) && (pre_ff == CYC_PER_SEC - 1);
  assign unit_tick = sec_tick && (units_sec_ff || (32'(min_ff) == SEC_PER_MIN - 1));
  assign expire = unit_tick && (cnt_ff == 8'h01) && !reload;
  assign timeout_evt = expire || force_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 32'h0000_0000;
      min_ff <= 8'h00;
    end else if (reload || state_ff != wde_pkg::WDE_COUNT) begin
      pre_ff <= 32'h0000_0000;
      min_ff <= 8'h00;
    end else if (sec_tick) begin
      pre_ff <= 32'h0000_0000;
      if (unit_tick) begin
        min_ff <= 8'h00;
      end else begin
        min_ff <= min_ff + 8'h01;
      end
    end else begin
      pre_ff <= pre_ff + 32'h0000_0001;
    end
  end

  // watchdog state and count; a forced timeout beats a restart in the same cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      wde_pkg::WDE_IDLE,
      wde_pkg::WDE_COUNT,
      wde_pkg::WDE_EXPIRED: begin
        if (force_evt || expire) begin
          nxt_state = wde_pkg::WDE_EXPIRED;
          nxt_cnt = 8'h00;
        end else if (reload) begin
          nxt_cnt = reload_val;
          if (reload_val == 8'h00) begin
            nxt_state = wde_pkg::WDE_IDLE;
          end else begin
            nxt_state = wde_pkg::WDE_COUNT;
          end
        end else if (unit_tick) begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = wde_pkg::WDE_IDLE;
        nxt_cnt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= wde_pkg::WDE_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign watchdog_timeout = ctrl_status_ff;

  // interrupt status: sticky, write one to clear, new event wins over the clear
  assign ist_set = {act_restart, timeout_evt};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= wde_pkg::RST_IRQ;
      imask_ff <= wde_pkg::RST_IRQ;
    end else begin
      if (wr_istat) begin
        ist_ff <= (ist_ff & ~pwdata[1:0]) | ist_set;
      end else begin
        ist_ff <= ist_ff | ist_set;
      end
      if (wr_imask) begin
        imask_ff <= pwdata[1:0];
      end
    end
  end

  assign irq = |(ist_ff & imask_ff);

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_line_rise;
    !kbc_level ##1 kbc_level;
  endsequence

  sequence s_force_write;
    wr_ctrl && pwdata[wde_pkg::CTRL_FORCE];
  endsequence

  property p_joy_restart;
    game_port_access && evsel_ff[wde_pkg::EVSEL_JOY] && !force_evt && !expire && !wr_timeout
      |=> cnt_ff == $past(timeout_ff);
  endproperty
  a_joy_restart: assert property (p_joy_restart) else $error("port access did not reload count");

  property p_joy_ignored;
    game_port_access && !evsel_ff[wde_pkg::EVSEL_JOY] && !kbd_irq && !mouse_irq && !wr_timeout
      && !force_evt && !unit_tick |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_joy_ignored: assert property (p_joy_ignored) else $error("disabled port access changed count");

  property p_kbd_restart;
    kbd_irq && evsel_ff[wde_pkg::EVSEL_KBD] && !force_evt && !wr_timeout && timeout_ff != 8'h00
      |=> state_ff == wde_pkg::WDE_COUNT && cnt_ff == $past(timeout_ff);
  endproperty
  a_kbd_restart: assert property (p_kbd_restart) else $error("keyboard irq did not restart");

  property p_mouse_restart;
    mouse_irq && evsel_ff[wde_pkg::EVSEL_MOUSE] && !force_evt && !wr_timeout && timeout_ff != 8'h00
      |=> state_ff == wde_pkg::WDE_COUNT && cnt_ff == $past(timeout_ff);
  endproperty
  a_mouse_restart: assert property (p_mouse_restart) else $error("mouse irq did not restart");

  property p_force_sets;
    s_force_write |=> ctrl_status_ff && state_ff == wde_pkg::WDE_EXPIRED;
  endproperty
  a_force_sets: assert property (p_force_sets) else $error("force bit did not time out");

  property p_force_reads_zero;
    setup && paddr == wde_pkg::ADDR_CTRL |=> !prdata[wde_pkg::CTRL_FORCE] && prdata[7:4] == 4'h0;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force bit not self clearing");

  property p_line_force;
    s_line_rise ##0 (ctrl_kbc_en_ff && kbc_rise) |=> ctrl_status_ff;
  endproperty
  a_line_force: assert property (p_line_force) else $error("line edge did not time out");

  property p_line_once;
    kbc_rise |=> !kbc_rise [*2];
  endproperty
  a_line_once: assert property (p_line_once) else $error("more than one pulse per edge");

  property p_line_masked;
    kbc_rise && !ctrl_kbc_en_ff && !(wr_ctrl && pwdata[wde_pkg::CTRL_FORCE]) |-> !force_evt;
  endproperty
  a_line_masked: assert property (p_line_masked) else $error("disabled line forced timeout");

  property p_zero_disables;
    reload && !wr_timeout && timeout_ff == 8'h00 && !force_evt |=> state_ff == wde_pkg::WDE_IDLE ##1 !expire;
  endproperty
  a_zero_disables: assert property (p_zero_disables) else $error("zero value did not disable");

  property p_count_write;
    wr_timeout && !force_evt |=> cnt_ff == 8'($past(pwdata));
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write did not load new value");

  property p_status_clear;
    wr_ctrl && !pwdata[wde_pkg::CTRL_STATUS] && !timeout_evt |=> !ctrl_status_ff;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status write of zero did not clear");

  property p_status_holds;
    ctrl_status_ff && !wr_ctrl |=> ctrl_status_ff;
  endproperty
  a_status_holds: assert property (p_status_holds) else $error("status dropped without a write");

  property p_force_no_state;
    s_force_write ##1 !wr_ctrl |-> !prdata_ff[wde_pkg::CTRL_FORCE];
  endproperty
  a_force_no_state: assert property (p_force_no_state) else $error("force bit left stored");

  property p_expire_flag;
    state_ff == wde_pkg::WDE_COUNT && cnt_ff == 8'h01 && unit_tick && !reload
      |=> ctrl_status_ff && state_ff == wde_pkg::WDE_EXPIRED && cnt_ff == 8'h00;
  endproperty
  a_expire_flag: assert property (p_expire_flag) else $error("expiry did not set status");

  property p_seconds_tick;
    units_sec_ff && sec_tick |-> unit_tick;
  endproperty
  a_seconds_tick: assert property (p_seconds_tick) else $error("seconds unit ignored");
endmodule

//--- design/wde_pkg.sv
// constants, register map and types for the watchdog event control block
package wde_pkg;
  // time base
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam longint unsigned ONE_SECOND_NS = 1000000000;
  localparam int unsigned CYCLES_PER_SECOND = int'(ONE_SECOND_NS / CLK_PERIOD_NS);
  localparam int unsigned SECONDS_PER_MINUTE = 60;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_UNITS = 8'h52;
  localparam logic [7:0] IDX_TIMEOUT = 8'h53;
  localparam logic [7:0] IDX_EVSEL = 8'h54;
  localparam logic [7:0] IDX_CTRL = 8'h55;
  localparam logic [7:0] IDX_ISTAT = 8'h60;
  localparam logic [7:0] IDX_IMASK = 8'h61;
  localparam logic [11:0] ADDR_UNITS = {2'b00, IDX_UNITS, 2'b00};
  localparam logic [11:0] ADDR_TIMEOUT = {2'b00, IDX_TIMEOUT, 2'b00};
  localparam logic [11:0] ADDR_EVSEL = {2'b00, IDX_EVSEL, 2'b00};
  localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_ISTAT = {2'b00, IDX_ISTAT, 2'b00};
  localparam logic [11:0] ADDR_IMASK = {2'b00, IDX_IMASK, 2'b00};

  // field positions
  localparam int EVSEL_JOY = 0;
  localparam int EVSEL_KBD = 1;
  localparam int EVSEL_MOUSE = 2;
  localparam int CTRL_STATUS = 0;
  localparam int CTRL_FORCE = 2;
  localparam int CTRL_KBC_EN = 3;
  localparam int UNITS_SEC = 7;
  localparam int IST_TIMEOUT = 0;
  localparam int IST_RESTART = 1;

  // reset values
  localparam logic [7:0] RST_EVSEL = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;
  localparam logic [7:0] RST_UNITS = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    WDE_IDLE = 3'b001,
    WDE_COUNT = 3'b010,
    WDE_EXPIRED = 3'b100
  } wde_state_t;
endpackage

//--- design/wde_sync.sv
// three-flop pin synchroniser with a one-cycle rising edge pulse
`timescale 1ns/1ps
module wde_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic rise_ff;

  // first flop feeds only the second one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // level changes only once flops two and three agree; edge pulse clears itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
      rise_ff <= (s2_ff == s3_ff) && s3_ff && !lvl_ff;
    end
  end

  assign level = lvl_ff;
  assign rise = rise_ff;
endmodule

//--- dv/wde_kbc_model.sv
// keyboard controller model driving the reset-request line
`timescale 1ns/1ps
module wde_kbc_model #(
  parameter int MIN_HIGH = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [7:0] hold,
  output logic line
);
  logic [11:0] cnt_ff;
  logic line_ff;
  assign line = line_ff;
  // one rising edge per request, held at least 1us and up to about 21us on demand
  // requests only come while the line is low, otherwise no new edge would appear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 12'h000;
      line_ff <= 1'b0;
    end else if (req) begin
      cnt_ff <= 12'(MIN_HIGH) + {2'b00, hold, 2'b00};
      line_ff <= 1'b1;
    end else if (cnt_ff != 12'h000) begin
      cnt_ff <= cnt_ff - 12'h001;
      line_ff <= (cnt_ff != 12'h001);
    end
  end
endmodule

//--- dv/tb_top.sv
// self-checking testbench for the watchdog event control block
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned CPS = 10;
  localparam int unsigned SPM = 3;
  localparam int MAX_CYC = 20000;
  localparam logic [11:0] A_UN = wde_pkg::ADDR_UNITS;
  localparam logic [11:0] A_TO = wde_pkg::ADDR_TIMEOUT;
  localparam logic [11:0] A_EV = wde_pkg::ADDR_EVSEL;
  localparam logic [11:0] A_CT = wde_pkg::ADDR_CTRL;
  localparam logic [11:0] A_IS = wde_pkg::ADDR_ISTAT;
  localparam logic [11:0] A_IM = wde_pkg::ADDR_IMASK;
  typedef struct {logic err; logic rd; logic [31:0] data;} wde_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] act = 3'b000;
  logic kbc_req = 1'b0;
  logic [7:0] kbc_hold = 8'h00;
  logic kbc_line;
  logic wdt;
  logic irq;
  wde_note_t notes[$];
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;

  always #10 pclk = ~pclk;

  wde_top #(.CYC_PER_SEC(CPS), .SEC_PER_MIN(SPM)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .game_port_access(act[0]), .kbd_irq(act[1]), .mouse_irq(act[2]),
    .kbc_reset_request_line(kbc_line), .watchdog_timeout(wdt), .irq(irq));
  wde_kbc_model kbc (.pclk(pclk), .presetn(presetn), .req(kbc_req), .hold(kbc_hold), .line(kbc_line));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // the watcher pops the oldest note at each completed access edge
  always @(posedge pclk) begin
    wde_note_t n;
    if (presetn && psel && penable && pready) begin
      if (notes.size() == 0) begin
        check("note queue", 32'h0000_0000, 32'h0000_0001);
      end else begin
        n = notes.pop_front();
        check("pslverr", {31'h0, pslverr}, {31'h0, n.err});
        if (n.rd) check("prdata", prdata, n.data);
      end
    end
  end

  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == MAX_CYC) begin
      check("run length", 32'h0000_0001, 32'h0000_0000);
      report_and_stop();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e,
                     input logic err);
    wde_note_t n;
    n.err = err;
    n.rd = !w;
    n.data = {24'h00_0000, e};
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    notes.push_back(n);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, e, 1'b0);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pulse(input int s);
    @(posedge pclk);
    act[s] <= 1'b1;
    @(posedge pclk);
    act[s] <= 1'b0;
  endtask

  task automatic kbc_edge(input logic [7:0] h);
    @(posedge pclk);
    kbc_hold <= h;
    kbc_req <= 1'b1;
    @(posedge pclk);
    kbc_req <= 1'b0;
  endtask

  // outputs are sampled at the falling edge, clear of the register updates
  task automatic chk_out(input logic w, input logic i);
    @(negedge pclk);
    check("watchdog_timeout", {31'h0, wdt}, {31'h0, w});
    check("irq", {31'h0, irq}, {31'h0, i});
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    logic [7:0] ev;
    void'($urandom(6));
    wait_cyc(16);
    presetn <= 1'b1;
    rd(A_UN, 8'h00);
    rd(A_TO, 8'h00);
    rd(A_EV, 8'h00);
    rd(A_CT, 8'h00);
    rd(A_IS, 8'h00);
    rd(A_IM, 8'h00);
    apb(1'b0, 12'h3F0, 8'h00, 8'h00, 1'b1);
    apb(1'b1, 12'h3F0, 8'hFF, 8'h00, 1'b1);
    end_test("reset");
    wr(A_CT, 8'h04);
    rd(A_CT, 8'h01);
    chk_out(1'b1, 1'b0);
    wr(A_CT, 8'h00);
    rd(A_CT, 8'h00);
    end_test("force");
    kbc_edge(8'h00);
    wait_cyc(80);
    rd(A_CT, 8'h00);
    wr(A_CT, 8'h08);
    kbc_edge(8'hFF);
    wait_cyc(10);
    rd(A_CT, 8'h09);
    wr(A_CT, 8'h08);
    wait_cyc(100);
    rd(A_CT, 8'h08);
    wr(A_CT, 8'h0C);
    rd(A_CT, 8'h09);
    wr(A_CT, 8'h08);
    while (kbc_line) @(posedge pclk);
    kbc_edge(8'($urandom));
    wait_cyc(10);
    rd(A_CT, 8'h09);
    while (kbc_line) @(posedge pclk);
    wr(A_CT, 8'h00);
    end_test("line force");
    wr(A_UN, 8'h80);
    rd(A_UN, 8'h80);
    wr(A_TO, 8'h02);
    wait_cyc(6);
    rd(A_CT, 8'h00);
    wait_cyc(20);
    rd(A_CT, 8'h01);
    chk_out(1'b1, 1'b0);
    wr(A_CT, 8'h00);
    wr(A_UN, 8'h00);
    wr(A_TO, 8'h01);
    wait_cyc(16);
    rd(A_CT, 8'h00);
    wait_cyc(25);
    rd(A_CT, 8'h01);
    wr(A_CT, 8'h00);
    wr(A_TO, 8'h00);
    wait_cyc(150);
    rd(A_CT, 8'h00);
    rd(A_TO, 8'h00);
    end_test("expiry");
    wr(A_UN, 8'h80);
    // off case enables the other two sources, so a swapped bit shows up
    for (int s = 0; s < 3; s++) begin
      for (int e = 0; e < 2; e++) begin
        ev = (e != 0) ? (8'h01 << s) : (8'h07 & ~(8'h01 << s));
        wr(A_EV, ev);
        rd(A_EV, ev);
        wr(A_CT, 8'h00);
        wr(A_TO, 8'h02);
        repeat (5) begin
          wait_cyc(8 + ($urandom % 7));
          pulse(s);
        end
        rd(A_CT, (e != 0) ? 8'h00 : 8'h01);
      end
    end
    end_test("restart");
    wr(A_TO, 8'hC8);
    wr(A_IS, 8'h03);
    wr(A_IM, 8'h00);
    wr(A_CT, 8'h04);
    rd(A_IS, 8'h01);
    chk_out(1'b1, 1'b0);
    wr(A_IM, 8'h01);
    chk_out(1'b1, 1'b1);
    wr(A_IS, 8'h01);
    chk_out(1'b1, 1'b0);
    rd(A_IS, 8'h00);
    wr(A_EV, 8'h02);
    pulse(1);
    rd(A_IS, 8'h02);
    wr(A_IM, 8'h02);
    chk_out(1'b1, 1'b1);
    wr(A_IS, 8'h02);
    chk_out(1'b1, 1'b0);
    wr(A_CT, 8'h00);
    wr(A_TO, 8'h00);
    end_test("interrupt");
    wait_cyc(4);
    report_and_stop();
  end
endmodule
